// ---- rtl/glo_cfg.svh ----
`ifndef GLO_CFG_SVH
`define GLO_CFG_SVH
// Clock and baud rates
`define GLO_CLK_HZ 25000000
`define GLO_BAUD_DEF 38400
`define GLO_BAUD_MID 19200
`define GLO_BAUD_LOW 9600
`define GLO_BAUD_DIV(b) (`GLO_CLK_HZ / (b))
`define GLO_MS_CYCLES (`GLO_CLK_HZ / 1000)
// Text frame characters
`define GLO_FRAME_LAST 4'hB
`define GLO_CH_SP 8'h20
`define GLO_CH_ZERO 8'h30
`define GLO_CH_PCT 8'h25
`define GLO_CH_L 8'h4C
`define GLO_CH_E 8'h45
`define GLO_CH_P 8'h70
`define GLO_CH_M 8'h6D
`define GLO_CH_CR 8'h0D
`define GLO_CH_LF 8'h0A
`define GLO_TEXT_MAX 15'h0063
// Two-wire slave
`define GLO_I2C_ADDR 7'h31
`define GLO_CMD_READ 8'h52
`define GLO_RESP_HDR 8'h08
`define GLO_RESV 8'h00
// Alarm defaults in percent of lower explosive limit
`define GLO_ALARM_ON_DEF 7'h19
`define GLO_ALARM_OFF_DEF 7'h14
// Pulse width output in milliseconds
`define GLO_PWM_START_MS 11'h002
`define GLO_PWM_SPAN_MS 1000
`define GLO_PWM_PERIOD_MS 11'h7D0
`define GLO_RANGE_LEL 7'h64
`define GLO_RANGE_PPM 15'h6978
`endif

// ---- rtl/glo_i2c_slave.sv ----
`timescale 1ns/10ps
`include "glo_cfg.svh"
module glo_i2c_slave
  import glo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Open drain pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Seven byte reply, header first
  input wire logic [55:0] resp_data
);
  // Bus phase, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } glo_i2c_state_type;
  glo_i2c_state_type state_reg;
  logic [2:0] scl_sync_reg; // Three stage synchroniser
  logic [2:0] sda_sync_reg;
  logic scl_f_reg, sda_f_reg, scl_p_reg, sda_p_reg; // Filtered and previous
  logic [7:0] shift_reg; // Byte in or out
  logic [2:0] bit_cnt_reg;
  logic [55:0] resp_reg; // Reply being sent
  logic is_addr_reg, rw_reg, ack_drv_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] byte_in;
  // ********************************
  // Pin conditioning
  // ********************************
  // Level counts once second and third stages agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_f_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_f_reg <= sda_sync_reg[2];
      scl_p_reg <= scl_f_reg;
      sda_p_reg <= sda_f_reg;
    end
  end
  assign scl_rise = scl_f_reg & ~scl_p_reg;
  assign scl_fall = ~scl_f_reg & scl_p_reg;
  assign start_cond = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg;
  assign stop_cond = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg;
  assign byte_in = {shift_reg[6:0], sda_f_reg};
  assign sda_out = 1'b0; // Only ever pulls low
  // ********************************
  // Protocol engine
  // ********************************
  // Address, command, acknowledge and reply shifting
  always_ff @(posedge clk)
  begin
    if (reset || stop_cond)
    begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      resp_reg <= 56'h0;
      is_addr_reg <= 1'b0;
      rw_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      // Start or repeated start
      state_reg <= ST_ADDR;
      sda_oe <= 1'b0;
      bit_cnt_reg <= 3'h0;
      is_addr_reg <= 1'b1;
      ack_drv_reg <= 1'b0; // A start cut into an acknowledge slot
    end
    else
      unique case (state_reg)
        ST_IDLE: ;
        ST_ADDR:
          if (scl_rise)
          begin
            shift_reg <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              // Address byte: command byte only after a write address
              if (is_addr_reg && byte_in[7:1] == `GLO_I2C_ADDR)
              begin
                rw_reg <= byte_in[0];
                state_reg <= ST_ACK;
                if (byte_in[0])
                  resp_reg <= resp_data;
              end
              else if (!is_addr_reg && byte_in == `GLO_CMD_READ)
              begin
                state_reg <= ST_ACK;
              end
              else
                state_reg <= ST_IDLE;
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            ack_drv_reg <= ~ack_drv_reg;
            if (!ack_drv_reg)
              sda_oe <= 1'b1;
            else if (is_addr_reg && rw_reg)
            begin
              // First reply bit goes out right away
              state_reg <= ST_TX;
              shift_reg <= {resp_reg[54:48], 1'b0};
              sda_oe <= ~resp_reg[55];
              bit_cnt_reg <= 3'h0;
            end
            else
            begin
              sda_oe <= 1'b0;
              is_addr_reg <= 1'b0;
              bit_cnt_reg <= 3'h0;
              state_reg <= is_addr_reg ? ST_ADDR : ST_IDLE;
            end
          end
        ST_TX:
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe <= (bit_cnt_reg == 3'h7) ? 1'b0 : ~shift_reg[7];
            if (bit_cnt_reg == 3'h7)
            begin
              state_reg <= ST_TXACK;
              resp_reg <= {resp_reg[47:0], `GLO_RESV};
            end
          end
        ST_TXACK:
          if (scl_rise && sda_f_reg)
            state_reg <= ST_IDLE; // Master ends the read
          else if (scl_fall)
          begin
            state_reg <= ST_TX;
            shift_reg <= {resp_reg[54:48], 1'b0};
            sda_oe <= ~resp_reg[55];
          end
        default: state_reg <= ST_IDLE;
      endcase
  end
  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_addr_ack_only: assert property (
    (state_reg == ST_ADDR && is_addr_reg && scl_rise && bit_cnt_reg == 3'h7 && !start_cond
     && !stop_cond && byte_in[7:1] != `GLO_I2C_ADDR) |=> state_reg == ST_IDLE)
    else $error("foreign address acknowledged");
  chk_read_dir: assert property (
    (state_reg == ST_ACK && is_addr_reg && ack_drv_reg && scl_fall && !stop_cond && !start_cond)
    |=> (state_reg == ST_TX) == rw_reg)
    else $error("direction bit misread");
  chk_resv_zero: assert property (
    (state_reg == ST_TX && $past(state_reg) == ST_TXACK) |-> resp_reg[7:0] == `GLO_RESV)
    else $error("reserved reply byte not zero");
endmodule

// ---- rtl/glo_pkg.sv ----
package glo_pkg;
  // One measurement from the sensing core
  typedef struct packed {
    logic valid;
    logic [6:0] lel;
    logic [14:0] ppm;
  } glo_sample_type;
  // Serial line rate choice
  typedef enum logic [1:0] {
    GLO_BAUD_38400 = 2'h0,
    GLO_BAUD_9600 = 2'h1,
    GLO_BAUD_19200 = 2'h2
  } glo_baud_type;
endpackage

// ---- rtl/glo_top.sv ----
`timescale 1ns/10ps
`include "glo_cfg.svh"
// Overview of operation
// - Twelve byte text frame ending LEL CRLF
// - Leading zero digits sent as spaces
// - Ppm variant: six digit field, ppm, CRLF
// - Two-wire slave answers address 0x31 only
// - Address bit 0 selects read or write
// - Reply: header, two value bytes, zeros
// - Alarm on above 25, off at 20
// - Alarm thresholds loadable from outside
// - Pulse high 2 ms plus scaled 1000 ms
// - Pulse full scale is 100 percent, or 27000 ppm in ppm mode
// - Serial 38400 8N1, or 9600, 19200
module glo_top
  import glo_pkg::*;
#(
  parameter int MS_CYCLES = `GLO_MS_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Measurement source
  input wire glo_sample_type sample,
  // Output options
  input wire logic ppm_mode,
  input wire glo_baud_type baud_sel,
  // Alarm threshold set-up
  input wire logic thr_load,
  input wire logic [6:0] thr_on_level,
  input wire logic [6:0] thr_off_level,
  // Serial text output
  output logic uart_txd,
  // Two-wire slave pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Alarm open collector and pulse output
  output logic alarm_out,
  output logic alarm_oe,
  output logic pwm_out
);
  logic [6:0] lel_reg; // Latest level, percent
  logic [14:0] ppm_reg; // Latest level, ppm
  logic [6:0] thr_on_reg, thr_off_reg; // Alarm thresholds
  logic alarm_reg;
  logic pend_reg; // Frame waiting to go out
  logic busy_reg; // Frame in progress
  logic txt_ppm_reg; // Frame format snapshot
  logic [14:0] txt_val_reg; // Frame value snapshot
  logic [3:0] byte_idx_reg, bit_idx_reg;
  logic [11:0] baud_cnt_reg;
  logic [11:0] baud_div; // Cycles per bit
  logic [7:0] tx_char; // Current frame character
  logic [15:0] ms_div_reg; // Millisecond divider
  logic ms_tick;
  logic [10:0] ms_cnt_reg; // Position in period
  logic [10:0] th_ms_reg; // High time, ms
  logic [15:0] resp_val; // Two-wire value field
  // ********************************
  // Helpers
  // ********************************
  // Decimal character at a digit position; leading zeros become spaces
  function automatic logic [7:0] dec_char(input logic [14:0] v, input logic [2:0] pos);
    logic [14:0] t;
    t = v;
    for (int i = 0; i < 5; i++)
      if (i < int'(pos))
        t = t / 15'd10;
    if (t == 15'h0 && pos != 3'h0)
      return `GLO_CH_SP;
    return `GLO_CH_ZERO + 8'(t % 15'd10);
  endfunction
  // ********************************
  // Latest measurement
  // ********************************
  // Text frame and two-wire reply are fed from these; alarm and pulse take the sample directly
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lel_reg <= 7'h00;
      ppm_reg <= 15'h0000;
    end
    else if (sample.valid)
    begin
      lel_reg <= sample.lel;
      ppm_reg <= sample.ppm;
    end
  end
  // ********************************
  // Alarm
  // ********************************
  // Threshold registers reload from the set-up port
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      thr_on_reg <= `GLO_ALARM_ON_DEF;
      thr_off_reg <= `GLO_ALARM_OFF_DEF;
    end
    else if (thr_load)
    begin
      thr_on_reg <= thr_on_level;
      thr_off_reg <= thr_off_level;
    end
  end
  // Hysteresis: on above upper level, off at or below lower
  always_ff @(posedge clk)
  begin
    if (reset)
      alarm_reg <= 1'b0;
    else if (sample.valid)
    begin
      if (sample.lel > thr_on_reg)
        alarm_reg <= 1'b1;
      else if (sample.lel <= thr_off_reg)
        alarm_reg <= 1'b0;
    end
  end
  assign alarm_out = 1'b0;
  assign alarm_oe = alarm_reg;
  // ********************************
  // Serial text frame
  // ********************************
  // Bit period from selected rate
  always_comb
  begin
    unique case (baud_sel)
      GLO_BAUD_9600: baud_div = 12'(`GLO_BAUD_DIV(`GLO_BAUD_LOW));
      GLO_BAUD_19200: baud_div = 12'(`GLO_BAUD_DIV(`GLO_BAUD_MID));
      default: baud_div = 12'(`GLO_BAUD_DIV(`GLO_BAUD_DEF));
    endcase
  end
  // Character at the current frame position
  always_comb
  begin
    tx_char = `GLO_CH_SP;
    if (txt_ppm_reg)
    begin
      unique case (byte_idx_reg)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
          tx_char = dec_char(txt_val_reg, 3'(4'h5 - byte_idx_reg));
        4'h7, 4'h8: tx_char = `GLO_CH_P;
        4'h9: tx_char = `GLO_CH_M;
        4'hA: tx_char = `GLO_CH_CR;
        4'hB: tx_char = `GLO_CH_LF;
        default: tx_char = `GLO_CH_SP;
      endcase
    end
    else
    begin
      unique case (byte_idx_reg)
        4'h3: tx_char = dec_char(txt_val_reg, 3'h1);
        4'h4: tx_char = dec_char(txt_val_reg, 3'h0);
        4'h5: tx_char = `GLO_CH_PCT;
        4'h7, 4'h9: tx_char = `GLO_CH_L;
        4'h8: tx_char = `GLO_CH_E;
        4'hA: tx_char = `GLO_CH_CR;
        4'hB: tx_char = `GLO_CH_LF;
        default: tx_char = `GLO_CH_SP;
      endcase
    end
  end
  // New sample queues a frame; a new sample beats the clear
  always_ff @(posedge clk)
  begin
    if (reset)
      pend_reg <= 1'b0;
    else if (sample.valid)
      pend_reg <= 1'b1;
    else if (!busy_reg)
      pend_reg <= 1'b0;
  end
  // Frame sequencer: start, 8 data bits lsb first, stop
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_reg <= 1'b0;
      txt_ppm_reg <= 1'b0;
      txt_val_reg <= 15'h0000;
      byte_idx_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      baud_cnt_reg <= 12'h000;
    end
    else if (!busy_reg)
    begin
      if (pend_reg)
      begin
        busy_reg <= 1'b1;
        txt_ppm_reg <= ppm_mode;
        // Two digit field tops out at 99
        txt_val_reg <= ppm_mode ? ppm_reg
          : (15'(lel_reg) > `GLO_TEXT_MAX ? `GLO_TEXT_MAX : 15'(lel_reg));
        byte_idx_reg <= 4'h0;
        bit_idx_reg <= 4'h0;
        baud_cnt_reg <= 12'h000;
      end
    end
    else if (baud_cnt_reg == baud_div - 12'h001)
    begin
      baud_cnt_reg <= 12'h000;
      if (bit_idx_reg == 4'h9)
      begin
        bit_idx_reg <= 4'h0;
        if (byte_idx_reg == `GLO_FRAME_LAST)
          busy_reg <= 1'b0;
        else
          byte_idx_reg <= byte_idx_reg + 4'h1;
      end
      else
        bit_idx_reg <= bit_idx_reg + 4'h1;
    end
    else
      baud_cnt_reg <= baud_cnt_reg + 12'h001;
  end
  // Line level, one cycle behind the sequencer
  always_ff @(posedge clk)
  begin
    if (reset || !busy_reg || bit_idx_reg == 4'h9)
      uart_txd <= 1'b1;
    else if (bit_idx_reg == 4'h0)
      uart_txd <= 1'b0;
    else
      uart_txd <= tx_char[3'(bit_idx_reg - 4'h1)];
  end
  // ********************************
  // Pulse width output
  // ********************************
  // Millisecond enable and position in the period
  always_ff @(posedge clk)
  begin
    if (reset || ms_tick)
      ms_div_reg <= 16'h0000;
    else
      ms_div_reg <= ms_div_reg + 16'h0001;
  end
  assign ms_tick = (ms_div_reg == 16'(MS_CYCLES - 1));
  always_ff @(posedge clk)
  begin
    if (reset)
      ms_cnt_reg <= 11'h000;
    else if (ms_tick)
      ms_cnt_reg <= (ms_cnt_reg == `GLO_PWM_PERIOD_MS - 11'h001) ? 11'h000
        : ms_cnt_reg + 11'h001;
  end
  // High time scaled over full range at each sample
  always_ff @(posedge clk)
  begin
    if (reset)
      th_ms_reg <= `GLO_PWM_START_MS;
    else if (sample.valid)
    begin
      if (ppm_mode)
        th_ms_reg <= `GLO_PWM_START_MS + 11'((25'(sample.ppm > `GLO_RANGE_PPM ? `GLO_RANGE_PPM
          : sample.ppm) * 25'(`GLO_PWM_SPAN_MS)) / 25'(`GLO_RANGE_PPM));
      else
        th_ms_reg <= `GLO_PWM_START_MS + 11'((17'(sample.lel > `GLO_RANGE_LEL ? `GLO_RANGE_LEL
          : sample.lel) * 17'(`GLO_PWM_SPAN_MS)) / 17'(`GLO_RANGE_LEL));
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      pwm_out <= 1'b0;
    else
      pwm_out <= ms_cnt_reg < th_ms_reg;
  end
  // ********************************
  // Two-wire reply
  // ********************************
  assign resp_val = ppm_mode ? 16'(ppm_reg) : 16'(lel_reg);
  glo_i2c_slave u_i2c
  (
    .clk(clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .resp_data({`GLO_RESP_HDR, resp_val, {4{`GLO_RESV}}})
  );
  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_frame_len: assert property (
    $fell(busy_reg) |-> $past(byte_idx_reg) == `GLO_FRAME_LAST)
    else $error("frame ended early");
  chk_zero_blank: assert property (
    (busy_reg && !txt_ppm_reg && byte_idx_reg == 4'h3 && txt_val_reg < 15'd10)
    |-> tx_char == `GLO_CH_SP)
    else $error("leading zero not blanked");
  chk_ppm_tail: assert property (
    (busy_reg && txt_ppm_reg && byte_idx_reg == 4'h9) |-> tx_char == `GLO_CH_M)
    else $error("ppm suffix wrong");
  chk_alarm_set: assert property (
    (sample.valid && sample.lel > thr_on_reg) |=> alarm_oe ##1 (alarm_oe || $past(sample.valid)))
    else $error("alarm not raised");
  chk_alarm_hold: assert property (
    (alarm_reg && sample.valid && sample.lel > thr_off_reg) |=> alarm_reg)
    else $error("alarm dropped above lower threshold");
  chk_pwm_start: assert property (
    (!$past(reset) && $past(ms_cnt_reg) < `GLO_PWM_START_MS) |-> pwm_out)
    else $error("start pulse missing");
  chk_pwm_scale: assert property (
    (sample.valid && !ppm_mode && sample.lel == `GLO_RANGE_LEL)
    |=> th_ms_reg == `GLO_PWM_START_MS + 11'(`GLO_PWM_SPAN_MS))
    else $error("full scale width wrong");
  chk_stop_bit: assert property (
    (busy_reg && bit_idx_reg == 4'h9) |=> uart_txd)
    else $error("stop bit not high");
  chk_same_sample: assert property (
    sample.valid |=> lel_reg == $past(sample.lel) && pend_reg)
    else $error("sample not taken");
endmodule

// ---- tb/glo_host_model.sv ----
`timescale 1ns/10ps
module glo_host_model #(
  parameter int BIT_CYCLES = 651,
  parameter int MS_CYCLES = 4,
  parameter int HALF = 12
)
(
  // Clock
  input wire logic clk,
  // Text line from the device
  input wire logic uart_txd,
  // Two-wire pins
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  output logic scl,
  output logic sda
);
  // ****************
  // Serial receiver
  // ****************
  logic [7:0] rx_q[$]; // Received bytes
  int stop_errs = 0; // Missing stop bits
  logic [7:0] rx_b; // Byte being assembled
  // Sample each bit mid-cell, 8N1, lsb first
  always
  begin
    @(negedge uart_txd);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge clk);
      rx_b[i] = uart_txd;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    if (uart_txd !== 1'b1)
      stop_errs++;
    rx_q.push_back(rx_b);
  end
  // ****************
  // Two-wire master
  // ****************
  logic m_scl_low = 1'b0; // Master holds clock low
  logic m_sda_low = 1'b0; // Master holds data low
  assign scl = ~m_scl_low;
  // Released lines float high through the pull-up
  assign sda = (dev_sda_oe ? dev_sda_out : 1'b1) & ~m_sda_low;
  // Wait a number of falling edges
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data falls while clock is high
  task automatic start();
    m_scl_low = 1'b0;
    w(HALF);
    m_sda_low = 1'b1;
    w(HALF);
    m_scl_low = 1'b1;
  endtask
  // Data rises while clock is high
  task automatic stop();
    w(3);
    m_sda_low = 1'b1;
    w(HALF);
    m_scl_low = 1'b0;
    w(HALF);
    m_sda_low = 1'b0;
    w(HALF);
  endtask
  // Data changes a few cycles after clock fall, so no false start
  task automatic bit_io(input logic b, output logic r);
    w(3);
    m_sda_low = ~b;
    w(HALF);
    m_scl_low = 1'b0;
    w(HALF);
    r = sda;
    m_scl_low = 1'b1;
  endtask
  // Write a byte msb first and return the acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Read a byte after the scaled one millisecond pause
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    w(MS_CYCLES);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule

// ---- tb/glo_top_test.sv ----
`timescale 1ns/10ps
module glo_top_test;
  import glo_pkg::*;
  // ****************
  // Clock, reset and stimulus
  // ****************
  localparam int MS = 4; // Cycles per millisecond in this run
  logic clk = 1'b0;
  logic reset = 1'b1;
  glo_sample_type sample = '0;
  logic ppm_mode = 1'b0;
  glo_baud_type baud_sel = GLO_BAUD_38400;
  logic thr_load = 1'b0;
  logic [6:0] thr_on = 7'h19;
  logic [6:0] thr_off = 7'h14;
  logic uart_txd, scl, sda, sda_out, sda_oe, alarm_out, alarm_oe, pwm_out;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic al_exp = 1'b0; // Expected alarm state
  logic [6:0] on_lvl = 7'h19; // Mirror of the thresholds
  logic [6:0] off_lvl = 7'h14;
  always #20 clk = ~clk;
  glo_top #(.MS_CYCLES(MS)) u_dut (
    .clk(clk), .reset(reset), .sample(sample), .ppm_mode(ppm_mode), .baud_sel(baud_sel),
    .thr_load(thr_load), .thr_on_level(thr_on), .thr_off_level(thr_off),
    .uart_txd(uart_txd), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .pwm_out(pwm_out)
  );
  glo_host_model #(.MS_CYCLES(MS)) u_host (
    .clk(clk), .uart_txd(uart_txd), .dev_sda_out(sda_out), .dev_sda_oe(sda_oe),
    .scl(scl), .sda(sda)
  );
  // ****************
  // Checking and reporting
  // ****************
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      mismatches++;
      summarize();
    end
  end
  // ****************
  // Expected values
  // ****************
  function automatic logic [7:0] frame_byte(input int i, input logic [6:0] v);
    case (i)
      3: return (v / 7'h0A == 7'h00) ? 8'h20 : 8'h30 + 8'(v / 7'h0A);
      4: return 8'h30 + 8'(v % 7'h0A);
      5: return 8'h25;
      7, 9: return 8'h4C;
      8: return 8'h45;
      10: return 8'h0D;
      11: return 8'h0A;
      default: return 8'h20;
    endcase
  endfunction
  function automatic logic [7:0] reply_byte(input int i, input logic [15:0] v);
    case (i)
      0: return 8'h08;
      1: return v[15:8];
      2: return v[7:0];
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic alarm_ref(input logic cur, input logic [6:0] lel);
    if (lel > on_lvl)
      return 1'b1;
    if (lel <= off_lvl)
      return 1'b0;
    return cur;
  endfunction
  // ****************
  // Drivers and tests
  // ****************
  // One-cycle sample, then one cycle for the outputs to follow
  task automatic send(input logic [6:0] lel, input logic [14:0] ppm);
    @(negedge clk);
    sample = '{valid: 1'b1, lel: lel, ppm: ppm};
    @(negedge clk);
    sample.valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic load_thr(input logic [6:0] on_v, input logic [6:0] off_v);
    @(negedge clk);
    thr_on = on_v;
    thr_off = off_v;
    thr_load = 1'b1;
    @(negedge clk);
    thr_load = 1'b0;
    on_lvl = on_v;
    off_lvl = off_v;
  endtask
  task automatic alarm_step(input logic [6:0] lel);
    send(lel, 15'h0000);
    al_exp = alarm_ref(al_exp, lel);
    check_bit(alarm_oe, al_exp);
  endtask
  task automatic i2c_read(input logic [15:0] v);
    logic ack;
    logic [7:0] b;
    u_host.start();
    u_host.put(8'h62, ack);
    check_bit(ack, 1'b1);
    u_host.put(8'h52, ack);
    check_bit(ack, 1'b1);
    u_host.stop();
    u_host.start();
    u_host.put(8'h63, ack);
    check_bit(ack, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      u_host.get(i < 6, b);
      check_byte(b, reply_byte(i, v));
    end
    u_host.stop();
  endtask
  // Count falling edges until the pulse line reaches a level
  task automatic wait_lvl(input logic lvl, inout logic [31:0] cnt);
    int n;
    n = 0;
    while (pwm_out !== lvl && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    cnt = cnt + n;
  endtask
  task automatic pwm_check(input logic [31:0] exp_ms);
    logic [31:0] hi;
    logic [31:0] per;
    hi = 0;
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, hi);
    hi = 0;
    wait_lvl(1'b0, hi);
    per = hi;
    wait_lvl(1'b1, per);
    check_count(hi, exp_ms * MS);
    check_count(per, 32'h7D0 * MS);
  endtask
  task automatic uart_test();
    int n;
    n = 0;
    // Whole first frame, then the head of the ppm frame for 27000
    while (u_host.rx_q.size() < 14 && n < 95000)
    begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 12; i++)
      check_byte(u_host.rx_q[i], frame_byte(i, 7'h07));
    check_byte(u_host.rx_q[12], 8'h20);
    check_byte(u_host.rx_q[13], 8'h32);
    check_count(u_host.stop_errs, 0);
    // Slower rate from here; the next character has a lone low start bit
    baud_sel = GLO_BAUD_19200;
    n = 0;
    while (uart_txd !== 1'b0 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (uart_txd === 1'b0 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    check_count(n, 25000000 / 19200);
    $display("test text frame done");
  endtask
  task automatic side_tests();
    logic [6:0] c1[5] = '{7'h19, 7'h1A, 7'h15, 7'h14, 7'h1A};
    logic [6:0] c2[5] = '{7'h23, 7'h29, 7'h1F, 7'h1E, 7'h64};
    logic [6:0] on_v;
    logic ack;
    // Threshold edges, hold band, then random levels and thresholds
    foreach (c1[i])
      alarm_step(c1[i]);
    load_thr(7'h28, 7'h1E);
    foreach (c2[i])
      alarm_step(c2[i]);
    for (int i = 0; i < 16; i++)
    begin
      on_v = 7'(20 + $urandom % 60);
      if (i % 4 == 0)
        load_thr(on_v, on_v - 7'(1 + $urandom % 15));
      alarm_step(7'($urandom % 101));
    end
    $display("test alarm done");
    // Foreign address and unknown command are refused
    u_host.start();
    u_host.put(8'h64, ack);
    check_bit(ack, 1'b0);
    u_host.stop();
    u_host.start();
    u_host.put(8'h62, ack);
    u_host.put(8'h41, ack);
    check_bit(ack, 1'b0);
    u_host.stop();
    send(7'h21, 15'h0000);
    i2c_read(16'h0021);
    $display("test two-wire done");
    send(7'h32, 15'h0000);
    pwm_check(32'h1F6);
    send(7'h00, 15'h0000);
    pwm_check(32'h2);
    $display("test pulse done");
    // Ppm scaling; the last sample feeds the ppm text frame that follows
    ppm_mode = 1'b1;
    send(7'h32, 15'h0A8C);
    pwm_check(32'h66);
    i2c_read(16'h0A8C);
    send(7'h64, 15'h6978);
    $display("test ppm scaling done");
  endtask
  initial
  begin
    void'($urandom(32'h1568));
    repeat (19) @(negedge clk);
    check_bit(uart_txd, 1'b1);
    check_bit(sda_oe, 1'b0);
    check_bit(alarm_oe, 1'b0);
    check_bit(pwm_out, 1'b0);
    check_bit(alarm_out, 1'b0);
    check_bit(sda_out, 1'b0);
    @(negedge clk);
    reset = 1'b0;
    send(7'h07, 15'h0000);
    fork
      uart_test();
      side_tests();
    join
    summarize();
  end
endmodule
